// >>> rtl/pfs_status_bank.sv
// latched fault/status bank with link-clock transaction port and alert pin
`timescale 1ns/1ps

module pfs_status_bank
  import pfs_pkg::*;
(
  // system clock and reset
  input  wire logic              sys_clk,
  input  wire logic              rst,
  // event sources, system clock domain
  input  wire logic              por_fault_evt,
  input  wire logic              selfcheck_busy,
  input  wire logic              followers_done,
  input  wire logic              restore_evt,
  input  wire logic              bcx_fault_evt,
  input  wire logic              sync_fault_evt,
  input  wire logic [15:0]       vin_reading,
  // transaction port, link clock domain
  input  wire logic              lk_clk,
  input  wire logic              cmd_valid,
  output logic                   cmd_ready,
  input  pfs_pkg::pfs_kind_e     cmd_kind,
  input  wire logic [7:0]        cmd_code,
  input  wire logic [15:0]       cmd_data,
  output logic                   rsp_valid,
  output logic [15:0]            rsp_data,
  // open-drain alert pin
  input  wire logic              alert_in,
  output logic                   alert_out,
  output logic                   alert_oe_n
);
  import pfs_pkg::*;

  typedef struct packed {
    logic      pend;
    logic      req_tgl;
    logic      ack_s1;
    logic      ack_s2;
    logic      ack_s3;
    pfs_kind_e kind;
    logic [7:0]  code;
    logic [15:0] data;
    logic        rsp_valid;
    logic [15:0] rsp_data;
  } pfs_link_s;

  typedef struct packed {
    logic        req_s1;
    logic        req_s2;
    logic        req_s3;
    logic        ack_tgl;
    logic [15:0] rsp;
    logic [7:0]  mfr;
    logic [7:0]  oth;
    logic [7:0]  cml;
    logic [7:0]  mask_mfr;
    logic [7:0]  mask_oth;
    logic [7:0]  mask_cml;
    logic        alert_drv;
    logic        alin_s1;
    logic        alin_s2;
  } pfs_sys_s;

  pfs_link_s l;
  pfs_link_s next_l;
  pfs_sys_s  s;
  pfs_sys_s  next_s;

  logic       go;
  logic [7:0] mfr_view;
  logic [7:0] summary;
  logic [7:0] mfr_set;
  logic [7:0] mfr_clr;
  logic [7:0] oth_clr;
  logic [7:0] cml_clr;
  logic       ivc_set;
  logic       unmasked;
  logic       origin_set;

  function automatic logic is_write(input pfs_kind_e k);
    is_write = (k == PFS_WR_BYTE) || (k == PFS_WR_WORD);
  endfunction

  // ---------------- link domain ----------------
  // fields stay held while pend is high, so the system side reads them
  // only after the request toggle has crossed
  always_comb
  begin
    next_l           = l;
    next_l.ack_s1    = s.ack_tgl;
    next_l.ack_s2    = l.ack_s1;
    next_l.ack_s3    = l.ack_s2;
    next_l.rsp_valid = 1'b0;
    if (l.ack_s2 ^ l.ack_s3)
    begin
      next_l.pend      = 1'b0;
      next_l.rsp_valid = 1'b1;
      next_l.rsp_data  = s.rsp;
    end
    if (cmd_valid && !l.pend)
    begin
      next_l.pend    = 1'b1;
      next_l.kind    = cmd_kind;
      next_l.code    = cmd_code;
      next_l.data    = cmd_data;
      next_l.req_tgl = ~l.req_tgl;
    end
  end

  always_ff @(posedge lk_clk or posedge rst)
  begin
    if (rst)
    begin
      l      <= '0;
    end
    else
    begin
      l      <= next_l;
    end
  end

  assign cmd_ready = ~l.pend;
  assign rsp_valid = l.rsp_valid;
  assign rsp_data  = l.rsp_data;

  // ---------------- system domain ----------------
  assign go = s.req_s2 ^ s.req_s3;

  // bit 6 is live, never stored
  always_comb
  begin
    mfr_view           = s.mfr & MFR_LATCH_MASK;
    mfr_view[MFR_SELF] = selfcheck_busy | ~followers_done;
  end

  // summary recomputed every cycle, so a clear drops it at once
  always_comb
  begin
    summary            = STATUS_RESET;
    summary[SUM_CML]   = |(s.cml & CML_LATCH_MASK);
    summary[SUM_OTHER] = |(s.oth & OTH_LATCH_MASK)
                       | |(s.mfr & MFR_LATCH_MASK);
  end

  always_comb
  begin
    mfr_set              = STATUS_RESET;
    mfr_set[MFR_POR]     = por_fault_evt;
    mfr_set[MFR_RESTORE] = restore_evt;
    mfr_set[MFR_BCX]     = bcx_fault_evt;
    mfr_set[MFR_SYNC]    = sync_fault_evt;
  end

  // unmasked latched vendor and cml sources; the live bit never alerts
  assign unmasked = |(s.mfr & MFR_LATCH_MASK & ~s.mask_mfr)
                  | |(s.cml & CML_LATCH_MASK & ~s.mask_cml);
  // alert_origin_flag: we start driving while the line is still released
  assign origin_set = unmasked & ~s.alert_drv & s.alin_s2;

  always_comb
  begin
    next_s         = s;
    next_s.req_s1  = l.req_tgl;
    next_s.req_s2  = s.req_s1;
    next_s.req_s3  = s.req_s2;
    next_s.alin_s1 = alert_in;
    next_s.alin_s2 = s.alin_s1;
    mfr_clr        = STATUS_RESET;
    oth_clr        = STATUS_RESET;
    cml_clr        = STATUS_RESET;
    ivc_set        = 1'b0;
    if (go)
    begin
      next_s.ack_tgl = ~s.ack_tgl;
      next_s.rsp     = RSP_RESET;
      case (l.code)
        CMD_CLEAR_FAULTS:
        begin
          if (is_write(l.kind))
          begin
            mfr_clr = MFR_LATCH_MASK;
            oth_clr = OTH_LATCH_MASK;
            cml_clr = CML_LATCH_MASK;
          end
          else
          begin
            ivc_set = 1'b1;
          end
        end
        CMD_VENDOR:
        begin
          if (l.kind == PFS_RD_BYTE)
            next_s.rsp = {8'h00, mfr_view};
          else if (l.kind == PFS_WR_BYTE)
            mfr_clr = l.data[7:0] & MFR_LATCH_MASK;
          else
            ivc_set = 1'b1;
        end
        CMD_OTHER:
        begin
          if (l.kind == PFS_RD_BYTE)
            next_s.rsp = {8'h00, s.oth & OTH_LATCH_MASK};
          else if (l.kind == PFS_WR_BYTE)
            oth_clr = l.data[7:0] & OTH_LATCH_MASK;
          else
            ivc_set = 1'b1;
        end
        CMD_CML:
        begin
          if (l.kind == PFS_RD_BYTE)
            next_s.rsp = {8'h00, s.cml & CML_LATCH_MASK};
          else if (l.kind == PFS_WR_BYTE)
            cml_clr = l.data[7:0] & CML_LATCH_MASK;
          else
            ivc_set = 1'b1;
        end
        CMD_SUMMARY:
        begin
          if (l.kind == PFS_RD_BYTE)
            next_s.rsp = {8'h00, summary};
          else
            ivc_set = 1'b1;
        end
        CMD_VIN:
        begin
          if (l.kind == PFS_RD_WORD)
            next_s.rsp = vin_reading;
          else
            ivc_set = 1'b1;
        end
        CMD_ALERT_MASK:
        begin
          // low byte names the status command, high byte is its mask
          if (l.kind == PFS_WR_WORD && l.data[7:0] == CMD_VENDOR)
            next_s.mask_mfr = l.data[15:8] & MFR_LATCH_MASK;
          else if (l.kind == PFS_WR_WORD && l.data[7:0] == CMD_CML)
            next_s.mask_cml = l.data[15:8] & CML_LATCH_MASK;
          else if (l.kind == PFS_WR_WORD && l.data[7:0] == CMD_OTHER)
            next_s.mask_oth = l.data[15:8] & OTH_LATCH_MASK;
          else
            ivc_set = 1'b1;
        end
        default:
        begin
          ivc_set = 1'b1;
        end
      endcase
    end
    // a set in the same cycle as its clear wins
    next_s.mfr = ((s.mfr & ~mfr_clr) | mfr_set) & MFR_LATCH_MASK;
    next_s.oth = (s.oth & ~oth_clr) & OTH_LATCH_MASK;
    next_s.oth[OTH_ORIGIN] = next_s.oth[OTH_ORIGIN] | origin_set;
    next_s.cml = (s.cml & ~cml_clr) & CML_LATCH_MASK;
    next_s.cml[CML_IVC] = next_s.cml[CML_IVC] | ivc_set;
    next_s.alert_drv = unmasked;
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

  // open drain: only ever pull low
  assign alert_out  = 1'b0;
  assign alert_oe_n = ~s.alert_drv;

  // ---------------- checks ----------------
  a_por_latch: assert property (@(posedge sys_clk) disable iff (rst)
    por_fault_evt |=> s.mfr[MFR_POR])
    else $error("power-on fault not latched");

  a_restore_hold: assert property (@(posedge sys_clk) disable iff (rst)
    s.mfr[MFR_RESTORE] && !mfr_clr[MFR_RESTORE] |=> s.mfr[MFR_RESTORE])
    else $error("restore bit lost without clear");

  a_bcx_latch: assert property (@(posedge sys_clk) disable iff (rst)
    bcx_fault_evt ##1 !mfr_clr[MFR_BCX] |=> s.mfr[MFR_BCX])
    else $error("back-channel fault not held");

  a_sync_latch: assert property (@(posedge sys_clk) disable iff (rst)
    sync_fault_evt |=> s.mfr[MFR_SYNC])
    else $error("sync fault not latched");

  a_w1c_clear: assert property (@(posedge sys_clk) disable iff (rst)
    go && l.code == CMD_VENDOR && l.kind == PFS_WR_BYTE
      && l.data[MFR_RESTORE] && !restore_evt |=> !s.mfr[MFR_RESTORE])
    else $error("write one did not clear");

  a_vendor_read: assert property (@(posedge sys_clk) disable iff (rst)
    go && l.code == CMD_VENDOR && l.kind == PFS_RD_BYTE
      |=> s.rsp[5:4] == 2'b00 && s.rsp[0] == 1'b0
        && s.rsp[MFR_SELF] == $past(selfcheck_busy | ~followers_done))
    else $error("vendor read wrong");

  a_ivc_ro: assert property (@(posedge sys_clk) disable iff (rst)
    go && l.code == CMD_VIN && is_write(l.kind) |=> s.cml[CML_IVC]
      ##1 summary[SUM_CML])
    else $error("write to read-only not flagged");

  a_alert_drive: assert property (@(posedge sys_clk) disable iff (rst)
    (|(s.mfr & ~s.mask_mfr)) |=> !alert_oe_n)
    else $error("alert not driven");

  a_origin_first: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(s.alert_drv) && $past(s.alin_s2) |-> s.oth[OTH_ORIGIN])
    else $error("origin flag missed");

  a_link_answer: assert property (@(posedge lk_clk) disable iff (rst)
    cmd_valid && cmd_ready |-> ##[2:10] rsp_valid)
    else $error("no answer on link");

endmodule

// >>> pkg/pfs_pkg.sv
// command codes, field positions and masks of the fault/status bank
package pfs_pkg;

  // command codes
  localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
  localparam logic [7:0] CMD_ALERT_MASK   = 8'h1B;
  localparam logic [7:0] CMD_SUMMARY      = 8'h78;
  localparam logic [7:0] CMD_CML          = 8'h7E;
  localparam logic [7:0] CMD_OTHER        = 8'h7F;
  localparam logic [7:0] CMD_VENDOR       = 8'h80;
  localparam logic [7:0] CMD_VIN          = 8'h88;

  // vendor status byte fields
  localparam int MFR_POR     = 7;
  localparam int MFR_SELF    = 6;
  localparam int MFR_RESTORE = 3;
  localparam int MFR_BCX     = 2;
  localparam int MFR_SYNC    = 1;

  // other, cml and summary fields
  localparam int OTH_ORIGIN  = 0;
  localparam int CML_IVC     = 7;
  localparam int SUM_CML     = 1;
  localparam int SUM_OTHER   = 0;

  // latched, clearable bits of each byte
  localparam logic [7:0] MFR_LATCH_MASK = 8'h8E;
  localparam logic [7:0] OTH_LATCH_MASK = 8'h01;
  localparam logic [7:0] CML_LATCH_MASK = 8'h80;

  // reset values
  localparam logic [7:0]  STATUS_RESET = 8'h00;
  localparam logic [7:0]  MASK_RESET   = 8'h00;
  localparam logic [15:0] RSP_RESET    = 16'h0000;

  // transaction kinds seen at the link
  typedef enum logic [1:0] {
    PFS_RD_BYTE,
    PFS_WR_BYTE,
    PFS_RD_WORD,
    PFS_WR_WORD
  } pfs_kind_e;

endpackage

// >>> tb/pfs_host.sv
// host model driving link transactions into the status bank
`timescale 1ns/1ps
module pfs_host
(
  // link clock
  input  wire logic          lk_clk,
  // transaction port
  output logic               cmd_valid,
  input  wire logic          cmd_ready,
  output pfs_pkg::pfs_kind_e cmd_kind,
  output logic [7:0]         cmd_code,
  output logic [15:0]        cmd_data,
  input  wire logic          rsp_valid,
  input  wire logic [15:0]   rsp_data
);
  import pfs_pkg::*;

  initial
  begin
    cmd_valid = 1'b0;
    cmd_kind  = PFS_RD_BYTE;
    cmd_code  = 8'h00;
    cmd_data  = 16'h0000;
  end

  // one request outstanding; a lost answer comes back unknown
  // everything moves and is sampled on the falling edge, away from the
  // rising edge at which the bank takes requests and launches answers
  task automatic xfer(input pfs_kind_e k, input logic [7:0] c,
                      input logic [15:0] d, output logic [15:0] rd);
    int n;
    rd = 'x;
    @(negedge lk_clk);
    cmd_valid = 1'b1;
    cmd_kind  = k;
    cmd_code  = c;
    cmd_data  = d;
    n = 0;
    // ready dropping shows the request was taken at the rising edge
    do @(negedge lk_clk); while (cmd_ready !== 1'b0 && ++n < 20);
    // idle code and data flip so stale values are never reused
    cmd_valid = 1'b0;
    cmd_code  = ~c;
    cmd_data  = ~d;
    repeat (20)
    begin
      @(negedge lk_clk);
      if (rsp_valid === 1'b1)
      begin
        rd = rsp_data;
        break;
      end
    end
  endtask
endmodule

// >>> tb/pfs_status_bank_test.sv
// self-checking bench for the fault/status bank
`timescale 1ns/1ps
module pfs_status_bank_test;
  import pfs_pkg::*;
  logic        sys_clk, lk_clk, rst, busy, fdone, other_pull;
  logic        alert_in, alert_out, alert_oe_n;
  logic        cmd_valid, cmd_ready, rsp_valid;
  logic [3:0]  ev;
  logic [7:0]  cmd_code;
  logic [15:0] vin, cmd_data, rsp_data;
  pfs_kind_e   cmd_kind;
  int          bad_count, n_checks;

  // pulled-up wire: released unless some party sinks it
  assign alert_in = (alert_oe_n ? 1'b1 : alert_out) & ~other_pull;

  pfs_status_bank dut
  (
    .sys_clk, .rst, .por_fault_evt(ev[3]), .selfcheck_busy(busy),
    .followers_done(fdone), .restore_evt(ev[2]), .bcx_fault_evt(ev[1]),
    .sync_fault_evt(ev[0]), .vin_reading(vin), .lk_clk, .cmd_valid,
    .cmd_ready, .cmd_kind, .cmd_code, .cmd_data, .rsp_valid, .rsp_data,
    .alert_in, .alert_out, .alert_oe_n
  );

  pfs_host host
  (
    .lk_clk, .cmd_valid, .cmd_ready, .cmd_kind, .cmd_code, .cmd_data,
    .rsp_valid, .rsp_data
  );

  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // unrelated phase to the system clock
  initial
  begin
    lk_clk = 1'b0;
    #7;
    forever #32 lk_clk = ~lk_clk;
  end

  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rd(input pfs_kind_e k, input logic [7:0] c,
                    input logic [15:0] e);
    logic [15:0] v;
    host.xfer(k, c, 16'h0000, v);
    chk(v, e);
  endtask

  // writes answer zero as well
  task automatic wr(input pfs_kind_e k, input logic [7:0] c,
                    input logic [15:0] d);
    logic [15:0] v;
    host.xfer(k, c, d, v);
    chk(v, 16'h0000);
  endtask

  // one-cycle event pulse, then room for latch and alert to land
  task automatic pulse(input logic [3:0] m);
    @(negedge sys_clk);
    ev = m;
    @(negedge sys_clk);
    ev = 4'h0;
    repeat (3) @(negedge sys_clk);
  endtask

  // look between system edges so the pin has settled
  task automatic alert(input logic e);
    @(negedge sys_clk);
    chk({15'h0000, alert_oe_n}, {15'h0000, e});
  endtask

  initial
  begin
    #100000;
    bad_count++;
    end_sim();
  end

  initial
  begin
    rst = 1'b1;
    busy = 1'b1;
    fdone = 1'b0;
    other_pull = 1'b0;
    ev = 4'h0;
    vin = 16'hD3A5;
    bad_count = 0;
    n_checks = 0;
    // slow link clock needs the reset to span its edges too
    repeat (8) @(negedge lk_clk);
    rst = 1'b0;
    rd(PFS_RD_BYTE, CMD_VENDOR, 16'h0040);
    rd(PFS_RD_BYTE, CMD_OTHER, 16'h0000);
    alert(1'b1);
    @(negedge sys_clk);
    busy = 1'b0;
    fdone = 1'b1;
    rd(PFS_RD_BYTE, CMD_VENDOR, 16'h0000);
    $display("reset test done");
    pulse(4'hF);
    alert(1'b0);
    rd(PFS_RD_BYTE, CMD_VENDOR, 16'h008E);
    rd(PFS_RD_BYTE, CMD_OTHER, 16'h0001);
    rd(PFS_RD_BYTE, CMD_SUMMARY, 16'h0001);
    wr(PFS_WR_BYTE, CMD_VENDOR, 16'h0008);
    rd(PFS_RD_BYTE, CMD_VENDOR, 16'h0086);
    wr(PFS_WR_BYTE, CMD_VENDOR, 16'h00FF);
    rd(PFS_RD_BYTE, CMD_VENDOR, 16'h0000);
    alert(1'b1);
    rd(PFS_RD_BYTE, CMD_SUMMARY, 16'h0001);
    wr(PFS_WR_BYTE, CMD_OTHER, 16'h0001);
    rd(PFS_RD_BYTE, CMD_OTHER, 16'h0000);
    rd(PFS_RD_BYTE, CMD_SUMMARY, 16'h0000);
    $display("latch test done");
    other_pull = 1'b1;
    repeat (4) @(negedge sys_clk);
    pulse(4'h2);
    rd(PFS_RD_BYTE, CMD_OTHER, 16'h0000);
    rd(PFS_RD_BYTE, CMD_VENDOR, 16'h0004);
    other_pull = 1'b0;
    wr(PFS_WR_BYTE, CMD_CLEAR_FAULTS, 16'h0000);
    rd(PFS_RD_BYTE, CMD_VENDOR, 16'h0000);
    $display("origin test done");
    wr(PFS_WR_WORD, CMD_ALERT_MASK, 16'h8080);
    pulse(4'h8);
    alert(1'b1);
    rd(PFS_RD_BYTE, CMD_VENDOR, 16'h0080);
    pulse(4'h4);
    alert(1'b0);
    wr(PFS_WR_BYTE, CMD_CLEAR_FAULTS, 16'h0000);
    $display("mask test done");
    rd(PFS_RD_WORD, CMD_VIN, 16'hD3A5);
    @(negedge sys_clk);
    vin = 16'h0BCD;
    rd(PFS_RD_WORD, CMD_VIN, 16'h0BCD);
    wr(PFS_WR_WORD, CMD_VIN, 16'h1234);
    rd(PFS_RD_BYTE, CMD_CML, 16'h0080);
    // the invalid-command alert starts on a released line: origin too
    rd(PFS_RD_BYTE, CMD_SUMMARY, 16'h0003);
    alert(1'b0);
    wr(PFS_WR_BYTE, CMD_CML, 16'h0080);
    rd(PFS_RD_BYTE, CMD_SUMMARY, 16'h0001);
    wr(PFS_WR_BYTE, CMD_OTHER, 16'h0001);
    rd(PFS_RD_BYTE, CMD_SUMMARY, 16'h0000);
    $display("telemetry test done");
    end_sim();
  end
endmodule
